/* File: design/line_sync.sv */
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are asynchronous to clk
// Notes:   only the second stage may be read by other logic
`timescale 1ns/100ps

module line_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pinLevel,
  output logic      [WIDTH-1:0] syncLevel
);

  logic [WIDTH-1:0] firstStage;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      firstStage <= '0;
      syncLevel  <= '0;
    end
    else
    begin
      firstStage <= pinLevel;
      syncLevel  <= firstStage;
    end
  end

endmodule

/* File: design/sticky_flag.sv */
// Purpose: one sticky event flag, set by hardware, cleared by a status read
// Assumes: set and clear are single-cycle strobes on clk
// Notes:   a set in the clearing cycle wins, so no event is lost
`timescale 1ns/100ps

module sticky_flag (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic setEvt,
  input  wire logic clearEvt,
  output logic      flag
);

  always_ff @(posedge clk)
  begin
    if (reset)
      flag <= 1'b0;
    else if (setEvt)
      flag <= 1'b1;
    else if (clearEvt)
      flag <= 1'b0;
  end

endmodule

/* File: design/timer_channel_status_irq.sv */
// Purpose: status flags, interrupt mask and request of one timer channel
// Assumes: event strobes, mode and drive levels come from the counter core on clk;
//          io line pin levels are asynchronous
// Notes:   registers reached over AXI4-Lite, one write and one read at a time
//          flags are set from mode-qualified events and gated by the mode again on the way out
//
// Notes on behaviour
// [R1] overflow flag, bit 0, set on counter overflow, cleared by status read
// [R2] capture mode: bit 1 set when a hold register loads twice unread
// [R3] waveform mode: bit 2 set when counter equals hold_a
// [R4] waveform mode: bit 3 set when counter equals hold_b
// [R5] any mode: bit 4 set when counter equals hold_c, cleared by read
// [R6] capture mode: bit 5 set whenever hold_a is loaded
// [R7] capture mode: bit 6 set whenever hold_b is loaded
// [R8] bit 7 set on external trigger, cleared by status read
// [R9] bit 16 shows live counter clock enable, never cleared by reading
// [R10] bit 17 mirrors line A: sampled pin in capture, driven level in waveform
// [R11] bit 18 mirrors line B: sampled pin in capture, driven level in waveform
// [R12] ones written to enable register bits 0..7 set mask bits
// [R13] ones written to disable register bits 0..7 clear mask bits
// [R14] mask register reads enabled interrupts in bits 0..7
// [R15] waveform-select bit: zero is capture mode, one is waveform mode
// [R16] interrupt request high while any flag and its mask bit are set; irq counts only flags visible in the current mode, one cycle later
`timescale 1ns/100ps

module timer_channel_status_irq
  import timer_status_pkg::*;
#(
  parameter int EVENTS = timer_status_pkg::EVT_COUNT
) (
  input  wire logic                               clk,
  input  wire logic                               reset,
  // register bus
  input  wire logic [timer_status_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                               awvalid,
  output logic                                    awready,
  input  wire logic [timer_status_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                         wstrb,
  input  wire logic                               wvalid,
  output logic                                    wready,
  output logic [1:0]                              bresp,
  output logic                                    bvalid,
  input  wire logic                               bready,
  input  wire logic [timer_status_pkg::ADDR_W-1:0] araddr,
  input  wire logic                               arvalid,
  output logic                                    arready,
  output logic [timer_status_pkg::DATA_W-1:0]      rdata,
  output logic [1:0]                              rresp,
  output logic                                    rvalid,
  input  wire logic                               rready,
  // counter core and io line pins
  input  wire logic                               waveMode,
  input  wire logic                               overflowEvt,
  input  wire logic                               matchAEvt,
  input  wire logic                               matchBEvt,
  input  wire logic                               matchCEvt,
  input  wire logic                               loadAEvt,
  input  wire logic                               loadBEvt,
  input  wire logic                               holdAReadEvt,
  input  wire logic                               holdBReadEvt,
  input  wire logic                               extTriggerEvt,
  input  wire logic                               clockEnabled,
  input  wire logic                               ioLineAPin,
  input  wire logic                               ioLineBPin,
  input  wire logic                               ioLineADrive,
  input  wire logic                               ioLineBDrive,
  // interrupt request
  output logic                                    irq
);

  import timer_status_pkg::*;

  logic [EVENTS-1:0] flags;
  logic [EVENTS-1:0] setVec;
  logic [EVENTS-1:0] visibleFlags;
  logic [EVENTS-1:0] irqMask;
  logic [1:0]        pinSync;
  logic              pendA;
  logic              pendB;
  logic              overrunEvt;
  logic              statusReadClr;
  logic              lineAMirror;
  logic              lineBMirror;
  logic              awHeld;
  logic              wHeld;
  logic [ADDR_W-1:0] awAddrHeld;
  logic [7:0]        wLowHeld;
  logic              wLowValid;
  logic              writeApply;
  logic              readAccept;
  logic              writeSet;
  logic              writeClear;
  logic [EVENTS-1:0] irqPending;
  logic [DATA_W-1:0] statusWord;
  logic [DATA_W-1:0] maskWord;

  // decode of mapped register words
  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    isMapped = (addr == OFS_STATUS) || (addr == OFS_IRQ_SET) ||
               (addr == OFS_IRQ_CLEAR) || (addr == OFS_IRQ_STATE);
  endfunction

  // mode-qualified view of one flag vector
  function automatic logic [EVENTS-1:0] modeGate(
    input logic [EVENTS-1:0] raw,
    input logic              wave
  );
    logic [EVENTS-1:0] gated;
    gated = raw;
    if (wave)
    begin
      gated[BIT_OVERRUN]   = 1'b0; // R2
      gated[BIT_CAPTURE_A] = 1'b0; // R6
      gated[BIT_CAPTURE_B] = 1'b0; // R7
    end
    else
    begin
      gated[BIT_MATCH_A] = 1'b0; // R3
      gated[BIT_MATCH_B] = 1'b0; // R4
    end
    modeGate = gated;
  endfunction

  // pin levels cross into clk before anything reads them
  line_sync #(
    .WIDTH (2)
  ) pinSyncInst (
    .clk       (clk),
    .reset     (reset),
    .pinLevel  ({ioLineBPin, ioLineAPin}),
    .syncLevel (pinSync)
  );

  // a hold register stays pending from its load until software reads it
  // a load in the reading cycle brings a new unread value, so pending stays
  always_ff @(posedge clk)
  begin
    if (reset)
      pendA <= 1'b0;
    else if (loadAEvt)
      pendA <= 1'b1;
    else if (holdAReadEvt)
      pendA <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      pendB <= 1'b0;
    else if (loadBEvt)
      pendB <= 1'b1;
    else if (holdBReadEvt)
      pendB <= 1'b0;
  end

  // a second load while pending, with no read in that cycle, is an overrun
  always_comb
  begin
    overrunEvt = (loadAEvt && pendA && !holdAReadEvt) ||
                 (loadBEvt && pendB && !holdBReadEvt); // R2
  end

  // event sources; overrun, match A/B and capture A/B qualified by the waveform-select bit
  always_comb
  begin
    setVec                = '0;
    setVec[BIT_OVERFLOW]  = overflowEvt; // R1
    setVec[BIT_OVERRUN]   = !waveMode && overrunEvt; // R2 R15
    setVec[BIT_MATCH_A]   = waveMode && matchAEvt; // R3 R15
    setVec[BIT_MATCH_B]   = waveMode && matchBEvt; // R4 R15
    setVec[BIT_MATCH_C]   = matchCEvt; // R5
    setVec[BIT_CAPTURE_A] = !waveMode && loadAEvt; // R6 R15
    setVec[BIT_CAPTURE_B] = !waveMode && loadBEvt; // R7 R15
    setVec[BIT_EXT_TRIG]  = extTriggerEvt; // R8
  end

  assign statusReadClr = readAccept && (araddr == OFS_STATUS);

  // one sticky flag per event; a read clears, a same-cycle event wins
  for (genvar i = 0; i < EVENTS; i++)
  begin : flagGen
    sticky_flag flagInst (
      .clk      (clk),
      .reset    (reset),
      .setEvt   (setVec[i]),
      .clearEvt (statusReadClr),
      .flag     (flags[i])
    );
  end

  assign visibleFlags = modeGate(flags, waveMode);

  // capture mode shows the sampled pin, waveform mode the driven level
  always_comb
  begin
    lineAMirror = waveMode ? ioLineADrive : pinSync[0]; // R10 R15
    lineBMirror = waveMode ? ioLineBDrive : pinSync[1]; // R11 R15
  end

  // status word as software sees it, mode gating already applied
  always_comb
  begin
    statusWord               = '0;
    statusWord[EVENTS-1:0]   = visibleFlags; // R1 R5 R8
    statusWord[BIT_CLOCK_ON] = clockEnabled; // R9
    statusWord[BIT_LINE_A]   = lineAMirror; // R10
    statusWord[BIT_LINE_B]   = lineBMirror; // R11
  end

  // enabled interrupts in the same layout as the flags
  always_comb
  begin
    maskWord             = '0;
    maskWord[EVENTS-1:0] = irqMask; // R14
  end

  // write address channel
  // ready returns only after the response is taken: one write in flight
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      awready    <= 1'b0;
      awHeld     <= 1'b0;
      awAddrHeld <= '0;
    end
    else if (awvalid && awready)
    begin
      awready    <= 1'b0;
      awHeld     <= 1'b1;
      awAddrHeld <= awaddr;
    end
    else if (writeApply)
      awHeld <= 1'b0;
    else if (!awHeld && !bvalid)
      awready <= 1'b1;
  end

  // write data channel; only byte lane 0 carries mask bits
  // wready follows the same rule as awready, so either may be taken first
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wready    <= 1'b0;
      wHeld     <= 1'b0;
      wLowHeld  <= '0;
      wLowValid <= 1'b0;
    end
    else if (wvalid && wready)
    begin
      wready    <= 1'b0;
      wHeld     <= 1'b1;
      wLowHeld  <= wdata[7:0];
      wLowValid <= wstrb[0];
    end
    else if (writeApply)
      wHeld <= 1'b0;
    else if (!wHeld && !bvalid)
      wready <= 1'b1;
  end

  assign writeApply = awHeld && wHeld && !bvalid;

  // write response
  // an unmapped word is answered with an error and has no effect
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else if (writeApply)
    begin
      bvalid <= 1'b1;
      bresp  <= isMapped(awAddrHeld) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid && bready)
      bvalid <= 1'b0;
  end

  // a write with byte lane 0 off changes nothing but is still answered
  assign writeSet   = writeApply && wLowValid && (awAddrHeld == OFS_IRQ_SET);
  assign writeClear = writeApply && wLowValid && (awAddrHeld == OFS_IRQ_CLEAR);

  // interrupt mask: set and clear registers act on ones only
  always_ff @(posedge clk)
  begin
    if (reset)
      irqMask <= MASK_RESET;
    else if (writeSet)
      irqMask <= irqMask | wLowHeld; // R12
    else if (writeClear)
      irqMask <= irqMask & ~wLowHeld; // R13
  end

  // read address and data channels
  // arready returns a cycle after the response, so reads come two cycles apart
  assign readAccept = arvalid && arready;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rresp   <= RESP_OKAY;
      rdata   <= '0;
    end
    else if (readAccept)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata   <= '0;
      unique case (araddr)
        OFS_STATUS:
          rdata <= statusWord; // R1 R5 R8 R9
        OFS_IRQ_STATE:
          rdata <= maskWord; // R14
        default:
          rdata <= '0;
      endcase
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
    else if (!rvalid)
      arready <= 1'b1;
  end

  // events both flagged in the current mode and enabled
  assign irqPending = visibleFlags & irqMask; // R16

  // request from the mode-qualified flags under the mask
  always_ff @(posedge clk)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |irqPending; // R16
  end

endmodule

/* File: design/timer_status_pkg.sv */
// Purpose: shared constants for the timer channel status and interrupt block
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses

package timer_status_pkg;

  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 32;
  localparam int          EVT_COUNT     = 8;

  localparam logic [3:0]  OFS_STATUS    = 4'h0;
  localparam logic [3:0]  OFS_IRQ_SET   = 4'h4;
  localparam logic [3:0]  OFS_IRQ_CLEAR = 4'h8;
  localparam logic [3:0]  OFS_IRQ_STATE = 4'hC;

  localparam int          BIT_OVERFLOW  = 0;
  localparam int          BIT_OVERRUN   = 1;
  localparam int          BIT_MATCH_A   = 2;
  localparam int          BIT_MATCH_B   = 3;
  localparam int          BIT_MATCH_C   = 4;
  localparam int          BIT_CAPTURE_A = 5;
  localparam int          BIT_CAPTURE_B = 6;
  localparam int          BIT_EXT_TRIG  = 7;
  localparam int          BIT_CLOCK_ON  = 16;
  localparam int          BIT_LINE_A    = 17;
  localparam int          BIT_LINE_B    = 18;

  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

/* File: dv/tb_top.sv */
// Purpose: self-checking bench for the timer status and interrupt block
// Assumes: AXI4-Lite master with ready lines held high
// Notes:   expected read and write answers queue up and are checked on arrival
`timescale 1ns/100ps
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end

module tb_top;
  import timer_status_pkg::*;
  logic        clk = 0, reset = 1, awvalid = 0, wvalid = 0, arvalid = 0;
  logic        bready = 1, rready = 1, waveMode = 0, clockEnabled = 1;
  logic        ioLineAPin = 0, ioLineBPin = 0, ioLineADrive = 0, ioLineBDrive = 0;
  logic [3:0]  awaddr = 0, araddr = 0, wstrb = 4'hF;
  logic [31:0] wdata = 0, rdata, m, d, p;
  logic [8:0]  evt = 0;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic [1:0]  expB;
  logic [33:0] expR;
  int          miscompares = 0, nTests = 0, cyc = 0, seed = 32'h0E877A10;
  wire         overflowEvt, matchAEvt, matchBEvt, matchCEvt, loadAEvt, loadBEvt;
  wire         extTriggerEvt, holdAReadEvt, holdBReadEvt;
  assign {overflowEvt, matchAEvt, matchBEvt, matchCEvt, loadAEvt, loadBEvt,
    extTriggerEvt, holdAReadEvt, holdBReadEvt} = evt;

  timer_channel_status_irq i_timer_channel_status_irq (.clk, .reset, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .waveMode, .overflowEvt,
    .matchAEvt, .matchBEvt, .matchCEvt, .loadAEvt, .loadBEvt, .holdAReadEvt,
    .holdBReadEvt, .extTriggerEvt, .clockEnabled, .ioLineAPin, .ioLineBPin,
    .ioLineADrive, .ioLineBDrive, .irq);

  always #12.5 clk = ~clk;

  // answers are compared in arrival order
  always @(posedge clk)
  begin
    if (bvalid && bready)
    begin
      expB = bq.pop_front();
      `CHK(bresp, expB)
    end
    if (rvalid && rready)
    begin
      expR = rq.pop_front();
      `CHK({rresp, rdata}, expR)
    end
    cyc++;
    if (cyc == 2000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
    bq.push_back(r);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
  endtask

  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
  endtask

  // one-cycle strobe then one settling edge
  task automatic ev(input logic [8:0] v);
    evt <= v;
    @(posedge clk);
    evt <= 0;
    @(posedge clk);
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    rd(OFS_IRQ_STATE, 34'h0);
    rd(OFS_STATUS, 34'h0_0001_0000);
    wr(4'h2, 32'hFF, RESP_SLVERR);
    rd(OFS_IRQ_STATE, 34'h0);
    $display("reset and unmapped done");
    m = $random(seed);
    d = $random(seed);
    wr(OFS_IRQ_SET, m, RESP_OKAY);
    wr(OFS_IRQ_CLEAR, d, RESP_OKAY);
    rd(OFS_IRQ_STATE, {26'h0, m[7:0] & ~d[7:0]});
    rd(OFS_IRQ_SET, 34'h0);
    $display("mask done");
    wr(OFS_IRQ_SET, 32'hFF, RESP_OKAY);
    ev(9'h1FC);
    @(posedge clk);
    `CHK(irq, 1'b1)
    rd(OFS_STATUS, 34'h0_0001_00F1);
    rd(OFS_STATUS, 34'h0_0001_0000);
    @(posedge clk);
    `CHK(irq, 1'b0)
    ev(9'h010);
    rd(OFS_STATUS, 34'h0_0001_0022);
    ev(9'h002);
    ev(9'h010);
    rd(OFS_STATUS, 34'h0_0001_0020);
    $display("capture done");
    waveMode <= 1;
    ioLineADrive <= 1;
    ev(9'h1FC);
    rd(OFS_STATUS, 34'h0_0003_009D);
    $display("waveform done");
    p = $random(seed);
    waveMode <= 0;
    clockEnabled <= 0;
    ioLineAPin <= p[0];
    ioLineBPin <= p[1];
    wr(OFS_IRQ_CLEAR, 32'hFF, RESP_OKAY);
    repeat (4) @(posedge clk);
    ev(9'h100);
    @(posedge clk);
    `CHK(irq, 1'b0)
    rd(OFS_STATUS, {2'h0, 13'h0, p[1:0], 1'b0, 16'h0001});
    $display("pins done");
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule

/* File: dv/timer_status_sva.sv */
// Purpose: bus-visible checks of the status and interrupt block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to the design top
`timescale 1ns/100ps

module timer_status_sva (
  input wire logic                                  clk,
  input wire logic                                  reset,
  input wire logic [timer_status_pkg::ADDR_W-1:0] araddr,
  input wire logic                                  arvalid,
  input wire logic                                  arready,
  input wire logic [timer_status_pkg::DATA_W-1:0] rdata,
  input wire logic                                  waveMode,
  input wire logic                                  overflowEvt,
  input wire logic                                  matchCEvt,
  input wire logic                                  extTriggerEvt,
  input wire logic                                  clockEnabled,
  input wire logic                                  irq
);
  import timer_status_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire rdS = arvalid && arready && araddr == OFS_STATUS;
  wire rdM = arvalid && arready && araddr == OFS_IRQ_STATE;
  property p_ovf; overflowEvt ##[1:2] rdS |=> rdata[BIT_OVERFLOW]; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag lost");
  property p_mc; matchCEvt ##[1:2] rdS |=> rdata[BIT_MATCH_C]; endproperty
  a_mc: assert property (p_mc) else $error("match c flag lost");
  property p_etr; extTriggerEvt ##[1:2] rdS |=> rdata[BIT_EXT_TRIG]; endproperty
  a_etr: assert property (p_etr) else $error("trigger flag lost");
  property p_clk; rdS |=> rdata[BIT_CLOCK_ON] == $past(clockEnabled); endproperty
  a_clk: assert property (p_clk) else $error("clock state wrong");
  property p_cap; rdS && !waveMode |=> rdata[3:2] == 2'h0; endproperty
  a_cap: assert property (p_cap) else $error("match flags in capture");
  property p_wav; rdS && waveMode |=> rdata[6:5] == 2'h0 && !rdata[1]; endproperty
  a_wav: assert property (p_wav) else $error("load flags in waveform");
  property p_msk; rdM |=> rdata[31:8] == 24'h0; endproperty
  a_msk: assert property (p_msk) else $error("mask upper bits set");
  property p_irq; rdM ##1 (rdata[7:0] == 8'h00) |-> !irq; endproperty
  a_irq: assert property (p_irq) else $error("request with empty mask");
  cover property (rdS && irq);
  cover property (overflowEvt ##[1:2] rdS);
  cover property (rdS && waveMode);
endmodule

bind timer_channel_status_irq timer_status_sva i_timer_status_sva (.clk, .reset, .araddr,
  .arvalid, .arready, .rdata, .waveMode, .overflowEvt, .matchCEvt, .extTriggerEvt,
  .clockEnabled, .irq);
